// ### design/rtc_irq_clksel.sv
// Interrupt, clock-source and event-flag logic of the real-time clock
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module rtc_irq_clksel (
   // Clock and reset
   input  wire logic                        SYS_CLK,
   input  wire logic                        RST,
   // Register port
   input  wire logic [rtc_irq_pkg::ADDR_W-1:0] REG_ADDR,
   input  wire logic [7:0]                  REG_WDATA,
   input  wire logic                        REG_WR,
   input  wire logic                        REG_RD,
   output logic      [7:0]                  REG_RDATA,
   // Calendar counters of the surrounding RTC
   input  wire logic [7:0]                  CAL_SECONDS,
   input  wire logic [2:0]                  CAL_DOW,
   input  wire logic                        CAL_HOUR_TICK,
   input  wire logic                        CAL_MIN_TICK,
   input  wire logic                        CAL_SEC_TICK,
   input  wire logic                        CAL_HALF_TICK,
   input  wire logic                        CAL_QTR_TICK,
   output logic                             CAL_RUN,
   // Chip state and subclock
   input  wire logic                        SUB_CLK,
   input  rtc_irq_pkg::pwr_mode_t           PWR_MODE,
   input  wire logic                        PIN_FUNC_EN,
   // Clock output pin
   output logic                             CLK_OUT,
   output logic                             CLK_OUT_EN,
   // Interrupt
   output logic                             IRQ
);
   import rtc_irq_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // True when the source code runs the free-running counter
   function automatic logic is_frc(input logic [3:0] src);
      is_frc = (src != SRC_CAL);
   endfunction

   // True for a source code software is allowed to write
   function automatic logic src_legal(input logic [3:0] src);
      src_legal = (src <= SRC_CAL);
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]           irq_en;         // Interrupt enable register
   logic [7:0]           next_irq_en;
   logic [7:0]           clk_src;        // Clock source register
   logic [7:0]           next_clk_src;
   logic [7:0]           flags;          // Event flag register
   logic [7:0]           next_flags;
   logic [7:0]           ctrl1;          // Control register one
   logic [7:0]           next_ctrl1;
   logic [7:0]           next_rdata;     // Read data for next cycle
   logic                 next_irq;       // Interrupt level

   // Free-running counter state
   logic [2:0]           prescale;       // Clock/8 prescaler
   logic [2:0]           next_prescale;
   logic [7:0]           frc_cnt;        // Free-running count
   logic [7:0]           next_frc_cnt;
   logic                 frc_tick;       // Prescaler wraps
   logic                 frc_ovf;        // Counter wraps past FF

   // Event detection state
   logic [2:0]           dow_prev;       // Last day-of-week seen
   logic [2:0]           next_dow_prev;
   logic [7:0]           evt;            // Events of this cycle
   logic                 cal_active;     // Calendar mode and running

   // Clock output state
   logic [CLKDIV_W-1:0]  clkdiv;         // System clock divider
   logic [CLKDIV_W-1:0]  next_clkdiv;
   logic                 sub_q;          // Sampled subclock
   logic                 next_clk_out;
   logic                 next_clk_out_en;
   logic                 next_cal_run;

   // Decoded control
   logic                 srst;           // Soft reset active
   logic                 run;            // Run bit
   logic                 frc_mode;       // Free-running mode
   logic                 wr_flags;       // Write to flag register

   assign srst     = ctrl1[CTRL_SRST_BIT];
   assign run      = ctrl1[CTRL_RUN_BIT];
   assign frc_mode = is_frc(clk_src[SRC_LSB +: SRC_W]);
   assign wr_flags = REG_WR && (REG_ADDR == ADDR_FLAGS);

   // ------------------------------------------------------------
   // Free-running counter
   // ------------------------------------------------------------

   // Prescaler and 8-bit counter advance only in free-running mode
   always_comb begin
      next_prescale = prescale;
      next_frc_cnt  = frc_cnt;
      frc_tick      = (prescale == 3'(FRC_PRESCALE - 1));
      frc_ovf       = 1'b0;
      if (srst) begin
         // Counter is a control circuit cleared by soft reset
         next_prescale = 3'h0;
         next_frc_cnt  = 8'h00;
      end else if (frc_mode && run) begin
         // Counts while run is one, holds while zero
         next_prescale = prescale + 3'h1;
         if (frc_tick) begin
            next_frc_cnt = frc_cnt + 8'h01;
            frc_ovf      = (frc_cnt == 8'hFF);
         end
      end else begin
         // Calendar mode or stopped: prescaler restarts
         next_prescale = 3'h0;
      end
   end

   // Register the counter state
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         prescale <= 3'h0;
         frc_cnt  <= 8'h00;
      end else begin
         prescale <= next_prescale;
         frc_cnt  <= next_frc_cnt;
      end
   end

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------

   // Collect the eight events in the shared bit order
   always_comb begin
      cal_active         = run && !frc_mode && !srst;
      next_dow_prev      = CAL_DOW;
      evt                = 8'h00;
      evt[BIT_OVF]       = frc_ovf;
      // Day event on any day-of-week count, week when it hits 0
      evt[BIT_DAY]       = cal_active && (CAL_DOW != dow_prev);
      evt[BIT_WEEK]      = cal_active && (CAL_DOW != dow_prev)
                           && (CAL_DOW == 3'h0);
      evt[BIT_HOUR]      = cal_active && CAL_HOUR_TICK;
      evt[BIT_MINUTE]    = cal_active && CAL_MIN_TICK;
      evt[BIT_SEC]       = cal_active && CAL_SEC_TICK;
      evt[BIT_HALF]      = cal_active && CAL_HALF_TICK;
      evt[BIT_QUARTER]   = cal_active && CAL_QTR_TICK;
   end

   // Remember the previous day-of-week value
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dow_prev <= 3'h0;
      end else begin
         dow_prev <= next_dow_prev;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------

   // Writes, soft reset, flag set and clear
   always_comb begin
      next_irq_en  = irq_en;
      next_clk_src = clk_src;
      next_ctrl1   = ctrl1;
      // Hardware only ever sets flags, never clears them
      next_flags   = flags | (evt & irq_en);
      if (REG_WR) begin
         unique case (REG_ADDR)
            ADDR_IRQ_EN: begin
               next_irq_en = REG_WDATA;
            end
            ADDR_CLK_SRC: begin
               // Bit 7 ignores writes; forbidden sources keep old one
               next_clk_src = (REG_WDATA & CSR_WMASK);
               if (!src_legal(REG_WDATA[SRC_LSB +: SRC_W])) begin
                  next_clk_src[SRC_LSB +: SRC_W] =
                     clk_src[SRC_LSB +: SRC_W];
               end
            end
            ADDR_FLAGS: begin
               // Zero bits clear, one bits leave alone; set wins
               next_flags = (flags & REG_WDATA)
                            | (evt & irq_en);
            end
            ADDR_CTRL1: begin
               next_ctrl1 = REG_WDATA & CTRL_WMASK;
            end
            default: begin
               // Seconds data and unmapped words ignore writes
            end
         endcase
      end
      if (srst) begin
         // Everything but the source register and the reset bit
         next_irq_en = REG8_RESET;
         next_flags  = REG8_RESET;
         next_ctrl1  = next_ctrl1 & CTRL_SRST_ONLY;
      end
      next_irq = |(next_flags & next_irq_en);
   end

   // Read data mux, valid only in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (REG_RD) begin
         unique case (REG_ADDR)
            ADDR_IRQ_EN:  next_rdata = irq_en;
            ADDR_CLK_SRC: next_rdata = clk_src & CSR_WMASK;
            ADDR_FLAGS:   next_rdata = flags;
            ADDR_CTRL1:   next_rdata = ctrl1;
            ADDR_SECONDS: begin
               next_rdata = frc_mode ? frc_cnt : CAL_SECONDS;
            end
            default:      next_rdata = 8'h00;
         endcase
      end
   end

   // Register file flip-flops
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         irq_en    <= REG8_RESET;
         clk_src   <= CSR_RESET;
         flags     <= REG8_RESET;
         ctrl1     <= CTRL_RESET;
         REG_RDATA <= 8'h00;
         IRQ       <= 1'b0;
      end else begin
         irq_en    <= next_irq_en;
         clk_src   <= next_clk_src;
         flags     <= next_flags;
         ctrl1     <= next_ctrl1;
         REG_RDATA <= next_rdata;
         IRQ       <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // Clock output
   // ------------------------------------------------------------

   // Select divided system clock or subclock, gated by power mode
   always_comb begin
      logic [OUT_W-1:0] sel;
      logic             div_val;
      logic             allowed;
      sel         = clk_src[OUT_LSB +: OUT_W];
      allowed     = 1'b0;
      next_clkdiv = clkdiv + 1'b1;
      // 000 /4, 010 /8, 100 /16, 110 /32 from one binary divider;
      // the tap index is three bits so code 110 reaches bit 4
      div_val     = clkdiv[{1'b0, sel[2:1]} + 3'h1];
      if (sel[0]) begin
         // Subclock runs in every mode but standby
         allowed = (PWR_MODE != PWR_STANDBY);
      end else begin
         allowed = (PWR_MODE == PWR_ACTIVE)
                   || (PWR_MODE == PWR_SLEEP);
      end
      next_clk_out    = PIN_FUNC_EN && allowed
                        && (sel[0] ? sub_q : div_val);
      next_clk_out_en = PIN_FUNC_EN;
      next_cal_run    = run && !frc_mode && !srst;
   end

   // Clock output flip-flops
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         clkdiv     <= '0;
         sub_q      <= 1'b0;
         CLK_OUT    <= 1'b0;
         CLK_OUT_EN <= 1'b0;
         CAL_RUN    <= 1'b0;
      end else begin
         clkdiv     <= next_clkdiv;
         sub_q      <= SUB_CLK;
         CLK_OUT    <= next_clk_out;
         CLK_OUT_EN <= next_clk_out_en;
         CAL_RUN    <= next_cal_run;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_flag_set_enable: assert property (
      (evt[BIT_MINUTE] && irq_en[BIT_MINUTE] && !srst)
         |=> flags[BIT_MINUTE])
      else $error("enabled minute event did not set its flag");

   a_srst_clears_all: assert property (
      srst |=> (irq_en == 8'h00) && (flags == 8'h00) && !IRQ)
      else $error("soft reset left enables or flags set");

   a_cal_holds_cnt: assert property (
      (!frc_mode && !srst) |=> $stable(frc_cnt))
      else $error("counter moved in calendar mode");

   a_frc_counts_up: assert property (
      (frc_mode && run && frc_tick && !srst)
         |=> frc_cnt == $past(frc_cnt) + 8'h01)
      else $error("free-running counter missed a tick");

   a_frc_tick_spacing: assert property (
      (frc_mode && run && !srst && prescale == 3'h0)
         ##1 (frc_mode && run && !srst)[*6]
         |=> frc_tick)
      else $error("prescaler not dividing by eight");

   a_seconds_readback: assert property (
      (REG_RD && REG_ADDR == ADDR_SECONDS && frc_mode)
         |=> REG_RDATA == $past(frc_cnt))
      else $error("seconds read did not return counter");

   a_ovf_irq: assert property (
      (frc_ovf && irq_en[BIT_OVF] && !srst
         && !(REG_WR && REG_ADDR == ADDR_IRQ_EN))
         |=> flags[BIT_OVF] && IRQ)
      else $error("overflow did not raise flag and interrupt");

   a_div_out_gated: assert property (
      (!clk_src[OUT_LSB] && PWR_MODE != PWR_ACTIVE
         && PWR_MODE != PWR_SLEEP) |=> !CLK_OUT)
      else $error("divided clock driven outside active or sleep");

   a_csr_bit7_zero: assert property (
      !clk_src[7])
      else $error("read-only source bit became set");

   a_flags_sticky: assert property (
      (!wr_flags && !srst) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag cleared without software write");

   a_write_one_noop: assert property (
      (wr_flags && REG_WDATA == 8'hFF && !srst)
         |=> (flags & $past(flags)) == $past(flags))
      else $error("writing one changed a flag");

   a_quarter_flag: assert property (
      (cal_active && CAL_QTR_TICK && irq_en[BIT_QUARTER])
         |=> flags[BIT_QUARTER])
      else $error("quarter-second event missed");

   a_week_on_zero: assert property (
      (cal_active && CAL_DOW == 3'h0 && $past(CAL_DOW) != 3'h0
         && irq_en[BIT_WEEK]) |=> flags[BIT_WEEK])
      else $error("day-of-week reaching zero did not set week flag");

endmodule

// ### design/rtc_irq_pkg.sv
// Shared constants and types of the RTC interrupt and clock-select block
package rtc_irq_pkg;

   // ------------------------------------------------------------
   // Register map (word index on the plain register port)
   // ------------------------------------------------------------
   localparam int          ADDR_W        = 3;
   localparam logic [2:0]  ADDR_IRQ_EN   = 3'h0; // Interrupt enables
   localparam logic [2:0]  ADDR_CLK_SRC  = 3'h1; // Clock source select
   localparam logic [2:0]  ADDR_FLAGS    = 3'h2; // Event flags
   localparam logic [2:0]  ADDR_CTRL1    = 3'h3; // Control register one
   localparam logic [2:0]  ADDR_SECONDS  = 3'h4; // Seconds data

   // ------------------------------------------------------------
   // Event bit positions, shared by enables and flags
   // ------------------------------------------------------------
   localparam int BIT_OVF     = 7;
   localparam int BIT_WEEK    = 6;
   localparam int BIT_DAY     = 5;
   localparam int BIT_HOUR    = 4;
   localparam int BIT_MINUTE  = 3;
   localparam int BIT_SEC     = 2;
   localparam int BIT_HALF    = 1;
   localparam int BIT_QUARTER = 0;

   // ------------------------------------------------------------
   // Control register one fields
   // ------------------------------------------------------------
   localparam int         CTRL_RUN_BIT   = 7;
   localparam int         CTRL_SRST_BIT  = 4;
   localparam logic [7:0] CTRL_WMASK     = 8'hF8; // Bits 2..0 read 0
   localparam logic [7:0] CTRL_SRST_ONLY = 8'h10; // Survives soft reset
   localparam logic [7:0] CTRL_RESET     = 8'h00;

   // ------------------------------------------------------------
   // Clock source register fields
   // ------------------------------------------------------------
   localparam int         SRC_LSB      = 0;
   localparam int         SRC_W        = 4;
   localparam int         OUT_LSB      = 4;
   localparam int         OUT_W        = 3;
   localparam logic [7:0] CSR_WMASK    = 8'h7F; // Bit 7 read-only zero
   localparam logic [7:0] CSR_RESET    = 8'h08;
   localparam logic [3:0] SRC_SYS_DIV8 = 4'h0;  // Free-running, clock/8
   localparam logic [3:0] SRC_CAL      = 4'h8;  // Subclock/4, calendar

   // ------------------------------------------------------------
   // Timing and reset values
   // ------------------------------------------------------------
   localparam int         FRC_PRESCALE = 8;     // System clock / 8
   localparam int         CLKDIV_W     = 5;     // Up to system clock / 32
   localparam logic [7:0] REG8_RESET   = 8'h00;

   // Power mode of the chip
   typedef enum logic [2:0] {
      PWR_ACTIVE    = 3'b000,
      PWR_SLEEP     = 3'b001,
      PWR_SUBACTIVE = 3'b010,
      PWR_SUBSLEEP  = 3'b011,
      PWR_WATCH     = 3'b100,
      PWR_STANDBY   = 3'b101
   } pwr_mode_t;

endpackage

// ### test/rtc_irq_clksel_tb.sv
// Self-checking testbench of the RTC interrupt and clock-select block
`timescale 1ns/1ps
module rtc_irq_clksel_tb;
   import rtc_irq_pkg::*;

   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic       sys_clk;              // 125 MHz system clock
   logic       rst;                  // Synchronous reset
   logic [2:0] reg_addr;             // Register word index
   logic [7:0] reg_wdata;            // Write data
   logic       reg_wr;               // Write strobe
   logic       reg_rd;               // Read strobe
   logic [7:0] reg_rdata;            // Read data
   logic [2:0] dow;                  // Day-of-week value
   logic [4:0] ticks;                // Hour, min, sec, half, quarter
   logic       cal_run;              // Calendar running
   logic       sub_clk;              // Subclock from the bench
   pwr_mode_t  pwr;                  // Chip power mode
   logic       pin_en;               // Clock pin function enable
   logic       clk_out;              // Clock output pin
   logic       clk_out_en;           // Clock pin enable copy
   logic       irq;                  // Interrupt level
   int         fail_count;           // Mismatches seen
   int         samples_checked;      // Comparisons made
   int         cycles;               // Timeout counter
   int         sub_cnt;              // Subclock divider
   logic [7:0] v;                    // Read value scratch
   int         n;                    // Edge count scratch

   // Register rows: address, write value, value read back
   logic [2:0] r_a [10] = '{0, 1, 1, 1, 3, 3, 5, 4, 2, 0};
   logic [7:0] r_w [10] = '{8'hA5, 8'hFF, 8'h98, 8'h08, 8'hE8,
                            8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
   logic [7:0] r_e [10] = '{8'hA5, 8'h78, 8'h18, 8'h08, 8'hE8,
                            8'h00, 8'h00, 8'h3C, 8'h00, 8'h00};
   // Clock-output rows: select word, mode, pin, rising edges in 128
   logic [7:0] c_s [10] = '{8'h08, 8'h28, 8'h48, 8'h68, 8'h08,
                            8'h68, 8'h18, 8'h18, 8'h38, 8'h08};
   pwr_mode_t  c_p [10] = '{PWR_ACTIVE, PWR_SLEEP, PWR_ACTIVE,
                            PWR_SLEEP, PWR_SUBACTIVE, PWR_WATCH,
                            PWR_WATCH, PWR_SUBSLEEP, PWR_ACTIVE,
                            PWR_ACTIVE};
   logic       c_n [10] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
   int         c_e [10] = '{32, 16, 8, 4, 0, 0, 13, 13, 13, 0};

   // ------------------------------------------------------------
   // Device under test
   // ------------------------------------------------------------
   rtc_irq_clksel dut_u (
      .SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .CAL_SECONDS(8'h3C), .CAL_DOW(dow),
      .CAL_HOUR_TICK(ticks[4]), .CAL_MIN_TICK(ticks[3]),
      .CAL_SEC_TICK(ticks[2]), .CAL_HALF_TICK(ticks[1]),
      .CAL_QTR_TICK(ticks[0]), .CAL_RUN(cal_run), .SUB_CLK(sub_clk),
      .PWR_MODE(pwr), .PIN_FUNC_EN(pin_en), .CLK_OUT(clk_out),
      .CLK_OUT_EN(clk_out_en), .IRQ(irq));

   // Clock generator, 8 ns period
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Subclock of ten system cycles; timeout guard
   always @(posedge sys_clk) begin
      sub_cnt <= (sub_cnt == 4) ? 0 : sub_cnt + 1;
      if (sub_cnt == 4) sub_clk <= ~sub_clk;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare one value and count it
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compare a count against a small window
   task automatic chk_rng(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, lo);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Read and compare
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // One calendar tick, then look at the interrupt line
   task automatic pulse(input int i, input logic exp_irq);
      @(posedge sys_clk);
      ticks <= 5'h01 << i;
      @(posedge sys_clk);
      ticks <= '0;
      @(posedge sys_clk);
      #1 chk({7'h00, irq}, {7'h00, exp_irq});
   endtask

   // Verdict and end of run
   task automatic end_of_test();
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
      reg_rd = 1'b0; dow = 3'h1; ticks = '0; sub_clk = 1'b0;
      pwr = PWR_ACTIVE; pin_en = 1'b0; fail_count = 0;
      samples_checked = 0; cycles = 0; sub_cnt = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset values
      #1 chk({4'h0, irq, clk_out, clk_out_en, cal_run}, 8'h00);
      rdc(ADDR_CLK_SRC, 8'h08);
      // Ordinary register rows
      for (int i = 0; i < 10; i++) begin
         wr(r_a[i], r_w[i]);
         rdc(r_a[i], r_e[i]);
      end
      // Calendar events, each set, checked and cleared by a zero
      wr(ADDR_IRQ_EN, 8'hFF);
      wr(ADDR_CTRL1, 8'h80);
      @(posedge sys_clk);
      #1 chk({7'h00, cal_run}, 8'h01);
      for (int i = 0; i < 5; i++) begin
         pulse(i, 1'b1);
         rdc(ADDR_FLAGS, 8'h01 << i);
         wr(ADDR_FLAGS, ~(8'h01 << i));
      end
      rdc(ADDR_FLAGS, 8'h00);
      @(posedge sys_clk) dow <= 3'h2;
      rdc(ADDR_FLAGS, 8'h20);
      wr(ADDR_FLAGS, 8'hDF);
      @(posedge sys_clk) dow <= 3'h0;
      rdc(ADDR_FLAGS, 8'h60);
      wr(ADDR_FLAGS, 8'hFF);
      rdc(ADDR_FLAGS, 8'h60);
      wr(ADDR_FLAGS, 8'hBF);
      repeat (50) @(posedge sys_clk);
      rdc(ADDR_FLAGS, 8'h20);
      // Masking and a disabled source
      wr(ADDR_IRQ_EN, 8'h00);
      pulse(0, 1'b0);
      rdc(ADDR_FLAGS, 8'h20);
      // Soft reset clears all but the source select and its own reset bit
      wr(ADDR_CLK_SRC, 8'h28);
      wr(ADDR_IRQ_EN, 8'hFF);
      wr(ADDR_CTRL1, 8'h10);
      rdc(ADDR_IRQ_EN, 8'h00);
      rdc(ADDR_FLAGS, 8'h00);
      rdc(ADDR_CLK_SRC, 8'h28);
      rdc(ADDR_CTRL1, 8'h10);
      wr(ADDR_CTRL1, 8'h00);
      // Stopped calendar records nothing
      wr(ADDR_IRQ_EN, 8'hFF);
      pulse(0, 1'b0);
      // Free-running counter from a cleared state
      wr(ADDR_CLK_SRC, 8'h00);
      wr(ADDR_CTRL1, 8'h80);
      @(posedge sys_clk);
      #1 chk({7'h00, cal_run}, 8'h00);
      pulse(1, 1'b0);
      wr(ADDR_CTRL1, 8'h10);
      wr(ADDR_CTRL1, 8'h00);
      wr(ADDR_IRQ_EN, 8'h80);
      repeat (40) @(posedge sys_clk);
      rdc(ADDR_SECONDS, 8'h00);
      wr(ADDR_CTRL1, 8'h80);
      repeat (80) @(posedge sys_clk);
      rd(ADDR_SECONDS, v);
      chk_rng(v, 10, 12);
      repeat (1980) @(posedge sys_clk);
      rdc(ADDR_FLAGS, 8'h80);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_CTRL1, 8'h00);
      wr(ADDR_FLAGS, 8'h7F);
      repeat (2) @(posedge sys_clk);
      #1 chk({7'h00, irq}, 8'h00);
      // Clock output rows
      for (int i = 0; i < 10; i++) begin
         wr(ADDR_CLK_SRC, c_s[i]);
         pwr <= c_p[i];
         pin_en <= c_n[i];
         repeat (4) @(posedge sys_clk);
         #1 chk({7'h00, clk_out_en}, {7'h00, c_n[i]});
         n = 0;
         v[0] = clk_out;
         repeat (128) begin
            @(posedge sys_clk);
            #1 if (clk_out && !v[0]) n++;
            v[0] = clk_out;
         end
         chk_rng(n, c_e[i] - 1, c_e[i] + 1);
      end
      end_of_test();
   end
endmodule
